// file: src/oag_consts.svh
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH
// What this block does
// - Index selector zero leaves the operand field alone, no addition.
// - Selector one to seven picks that low scratchpad register as index.
// - Index register is added to the 16-bit operand field, carry dropped.
// - Indirect flag one asks for indirection after indexing; zero means none.
// - With indirection, mode bit one is memory indirect, zero register indirect.
// - Memory indirect reads task memory and replaces modifier, operand, mode, then restarts.
// - Register indirect moves bits 28-31 and 17, flags write-back, saves selector.
// - Operand field then loads from the selected scratchpad register; indexing repeats.
// - With write-back flagged, the indexed operand goes back into that register.
// - Indexing and indirection repeat until the indirect flag is zero.
// - The final mode bit chooses literal operand or operand address.
// - A physical operand address goes straight to memory, no kernel lookup.
// - Virtual address bits 16-23 pick a kernel word in the kernel page.
// - Page-oriented read-only memory page is copied into task memory if absent.
// - A main memory page load moves 256 consecutive words from the addressed word.
// - A mid-page load wraps to the first word of the same page.
// - Task page number goes into kernel bits 0-7 and forms the address.
// - Word-oriented displacement is an eight-bit sum with the carry suppressed.
// - Word-oriented main address is kernel bits 12-23 then the new displacement.
// - Kernel bit 10 tells whether the page sits in the named task page.
// - A page brought in on demand sets the kernel residency flag.
// - A two-bit kernel page pointer names the task page holding the kernel.

// -----------------------------------------------------------------
// Instruction word fields (documentation bit n sits at index 35-n)
// -----------------------------------------------------------------
`define OAG_W_INDIR 23
`define OAG_W_MOD_HI 23
`define OAG_W_MOD_LO 20
`define OAG_W_SEL_HI 22
`define OAG_W_SEL_LO 20
`define OAG_W_OP_HI 19
`define OAG_W_OP_LO 4
`define OAG_W_WBK 19
`define OAG_W_NTAG 18
`define OAG_W_RSEL_HI 12
`define OAG_W_RSEL_LO 8
`define OAG_W_NMOD_HI 7
`define OAG_W_NMOD_LO 4
`define OAG_W_MODE 3
`define OAG_W_SUB_HI 23
`define OAG_W_SUB_LO 3
`define OAG_W_KIDX_HI 19
`define OAG_W_KIDX_LO 12
`define OAG_W_DISP_HI 11
`define OAG_W_DISP_LO 4

// -----------------------------------------------------------------
// Kernel word fields
// -----------------------------------------------------------------
`define OAG_K_TMPG_HI 35
`define OAG_K_TMPG_LO 28
`define OAG_K_RES 25
`define OAG_K_PW 24
`define OAG_K_UNIT_HI 23
`define OAG_K_UNIT_LO 20
`define OAG_K_ROMU_HI 23
`define OAG_K_ROMU_LO 16
`define OAG_K_ROMPG_HI 15
`define OAG_K_ROMPG_LO 4
`define OAG_K_MPG_HI 23
`define OAG_K_MPG_LO 12
`define OAG_K_DISP_HI 11
`define OAG_K_DISP_LO 4
`define OAG_K_PAR 0

// -----------------------------------------------------------------
// Values
// -----------------------------------------------------------------
`define OAG_NO_INDEX 3'h0
`define OAG_LAST_WORD 8'hFF
`define OAG_FIRST_WORD 8'h00
`define OAG_KPR_RESET 2'h0
`define OAG_KPG_PAD 6'h00
`define OAG_LIT_PAD 4'h0
`define OAG_IDX_PAD 2'h0

`endif

// file: src/oag_pkg.sv
package oag_pkg;

  typedef enum logic [3:0] {
    S_IDLE,
    S_INDEX,
    S_MEMIND,
    S_REGIND,
    S_FINAL,
    S_KWRD,
    S_KWCHK,
    S_XFERRD,
    S_XFERWR,
    S_KWWR,
    S_OUT
  } oag_state_e;

  typedef struct packed {
    oag_state_e state;
    logic [35:0] word;
    logic [35:0] kw;
    logic [35:0] xbuf;
    logic [7:0] cnt;
    logic [7:0] loadPage;
    logic fromMain;
    logic wbPending;
    logic [4:0] savedSel;
    logic [1:0] kernel_page_pointer;
    logic opIsLiteral;
    logic opInMain;
    logic [19:0] opAddr;
  } oag_regs_s;

endpackage

// file: src/oag_addr_form.sv
`timescale 1ns/100ps
`include "oag_consts.svh"

module oag_addr_form (
  // Current words
  input wire logic [35:0] word,
  input wire logic [35:0] kw,
  input wire logic [1:0] kernel_page_pointer,
  // Page load progress
  input wire logic [7:0] loadPage,
  input wire logic [7:0] cnt,
  // Formed addresses
  output logic [15:0] kwAddr,
  output logic [19:0] wordMainAddr,
  output logic [15:0] resTmAddr,
  output logic [15:0] loadTmAddr,
  output logic [19:0] srcMainAddr,
  output logic [27:0] srcRomAddr,
  output logic [15:0] dstTmAddr
);

  // Eight-bit sum; the carry is dropped so the page never changes
  function automatic logic [7:0] addByte(input logic [7:0] a, input logic [7:0] b);
    addByte = a + b;
  endfunction

  logic [7:0] disp;

  assign disp = word[`OAG_W_DISP_HI:`OAG_W_DISP_LO];
  assign kwAddr = {`OAG_KPG_PAD, kernel_page_pointer, word[`OAG_W_KIDX_HI:`OAG_W_KIDX_LO]};
  assign wordMainAddr = {kw[`OAG_K_MPG_HI:`OAG_K_MPG_LO],
                         addByte(kw[`OAG_K_DISP_HI:`OAG_K_DISP_LO], disp)};
  assign resTmAddr = {kw[`OAG_K_TMPG_HI:`OAG_K_TMPG_LO], disp};
  assign loadTmAddr = {loadPage, disp};
  // Wrap inside the source page when the start is mid-page
  assign srcMainAddr = {kw[`OAG_K_MPG_HI:`OAG_K_MPG_LO],
                        addByte(kw[`OAG_K_DISP_HI:`OAG_K_DISP_LO], cnt)};
  assign srcRomAddr = {kw[`OAG_K_ROMU_HI:`OAG_K_ROMU_LO],
                       kw[`OAG_K_ROMPG_HI:`OAG_K_ROMPG_LO], cnt};
  assign dstTmAddr = {loadPage, cnt};

endmodule

// file: src/oag_top.sv
`timescale 1ns/100ps
`include "oag_consts.svh"

module oag_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Instruction from fetch stage
  input wire logic instrValid,
  input wire logic [35:0] instrWord,
  output logic instrReady,
  // Configuration
  input wire logic virtualMode,
  input wire logic [3:0] mainUnitPrefix,
  input wire logic [7:0] freePage,
  input wire logic kprLoad,
  input wire logic [1:0] kprIn,
  output logic [1:0] kernelPagePointer,
  // Scratchpad registers
  output logic [4:0] spRdAddr,
  input wire logic [15:0] spRdData,
  output logic spWrEn,
  output logic [4:0] spWrAddr,
  output logic [15:0] spWrData,
  // Task memory
  output logic tmReq,
  output logic tmWe,
  output logic [15:0] tmAddr,
  output logic [35:0] tmWrData,
  input wire logic [35:0] tmRdData,
  input wire logic tmAck,
  // Main data memory
  output logic mmReq,
  output logic [19:0] mmAddr,
  input wire logic [35:0] mmRdData,
  input wire logic mmAck,
  // Block read-only memory
  output logic romReq,
  output logic [27:0] romAddr,
  input wire logic [35:0] romRdData,
  input wire logic romAck,
  // Operand result
  output logic opValid,
  output logic opIsLiteral,
  output logic opInMain,
  output logic [19:0] opAddr,
  input wire logic opReady
);

  oag_pkg::oag_regs_s r_reg;
  oag_pkg::oag_regs_s r_next;

  logic [15:0] kwAddr;
  logic [19:0] wordMainAddr;
  logic [15:0] resTmAddr;
  logic [15:0] loadTmAddr;
  logic [19:0] srcMainAddr;
  logic [27:0] srcRomAddr;
  logic [15:0] dstTmAddr;
  logic [2:0] idxSel;
  logic [15:0] opField;
  logic [15:0] idxOp;
  logic [35:0] kwNew;
  logic srcAck;
  logic [35:0] srcData;

  oag_addr_form i_oag_addr_form (
    .word(r_reg.word),
    .kw(r_reg.kw),
    .kernel_page_pointer(r_reg.kernel_page_pointer),
    .loadPage(r_reg.loadPage),
    .cnt(r_reg.cnt),
    .kwAddr(kwAddr),
    .wordMainAddr(wordMainAddr),
    .resTmAddr(resTmAddr),
    .loadTmAddr(loadTmAddr),
    .srcMainAddr(srcMainAddr),
    .srcRomAddr(srcRomAddr),
    .dstTmAddr(dstTmAddr)
  );

  // -----------------------------------------------------------------
  // Datapath terms
  // -----------------------------------------------------------------
  assign idxSel = r_reg.word[`OAG_W_SEL_HI:`OAG_W_SEL_LO];
  assign opField = r_reg.word[`OAG_W_OP_HI:`OAG_W_OP_LO];
  // Sum is cut to 16 bits, so a carry out of the field is lost
  assign idxOp = (idxSel == `OAG_NO_INDEX) ? opField : opField + spRdData;

  // Kernel word after a page load: page number, residency, fresh odd parity
  always_comb begin
    kwNew = r_reg.kw;
    kwNew[`OAG_K_TMPG_HI:`OAG_K_TMPG_LO] = r_reg.loadPage;
    kwNew[`OAG_K_RES] = 1'b1;
    kwNew[`OAG_K_PAR] = ~^kwNew[35:1];
  end

  assign srcAck = r_reg.fromMain ? mmAck : romAck;
  assign srcData = r_reg.fromMain ? mmRdData : romRdData;

  // -----------------------------------------------------------------
  // Ports driven from state
  // -----------------------------------------------------------------
  assign instrReady = (r_reg.state == oag_pkg::S_IDLE);
  assign kernelPagePointer = r_reg.kernel_page_pointer;
  // Register indirect reads the selector field of the word, indexing reads the index register
  assign spRdAddr = (r_reg.state == oag_pkg::S_REGIND) ?
                    r_reg.word[`OAG_W_RSEL_HI:`OAG_W_RSEL_LO] :
                    {`OAG_IDX_PAD, idxSel};
  assign spWrEn = (r_reg.state == oag_pkg::S_INDEX) && r_reg.wbPending;
  assign spWrAddr = r_reg.savedSel;
  assign spWrData = idxOp;
  assign tmReq = (r_reg.state == oag_pkg::S_MEMIND) || (r_reg.state == oag_pkg::S_KWRD) ||
                 (r_reg.state == oag_pkg::S_XFERWR) || (r_reg.state == oag_pkg::S_KWWR);
  assign tmWe = (r_reg.state == oag_pkg::S_XFERWR) || (r_reg.state == oag_pkg::S_KWWR);
  assign tmWrData = (r_reg.state == oag_pkg::S_KWWR) ? kwNew : r_reg.xbuf;
  assign mmReq = (r_reg.state == oag_pkg::S_XFERRD) && r_reg.fromMain;
  assign mmAddr = srcMainAddr;
  assign romReq = (r_reg.state == oag_pkg::S_XFERRD) && !r_reg.fromMain;
  assign romAddr = srcRomAddr;
  assign opValid = (r_reg.state == oag_pkg::S_OUT);
  assign opIsLiteral = r_reg.opIsLiteral;
  assign opInMain = r_reg.opInMain;
  assign opAddr = r_reg.opAddr;

  always_comb begin
    unique case (r_reg.state)
      oag_pkg::S_MEMIND: tmAddr = opField;
      oag_pkg::S_KWRD: tmAddr = kwAddr;
      oag_pkg::S_XFERWR: tmAddr = dstTmAddr;
      oag_pkg::S_KWWR: tmAddr = kwAddr;
      default: tmAddr = opField;
    endcase
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    if (kprLoad) begin
      r_next.kernel_page_pointer = kprIn;
    end
    unique case (r_reg.state)
      oag_pkg::S_IDLE: begin
        if (instrValid) begin
          r_next.word = instrWord;
          r_next.wbPending = 1'b0;
          r_next.state = oag_pkg::S_INDEX;
        end
      end
      oag_pkg::S_INDEX: begin
        r_next.word[`OAG_W_OP_HI:`OAG_W_OP_LO] = idxOp;
        r_next.wbPending = 1'b0;
        if (!r_reg.word[`OAG_W_INDIR]) begin
          r_next.state = oag_pkg::S_FINAL;
        end else if (r_reg.word[`OAG_W_MODE]) begin
          r_next.state = oag_pkg::S_MEMIND;
        end else begin
          r_next.state = oag_pkg::S_REGIND;
        end
      end
      oag_pkg::S_MEMIND: begin
        if (tmAck) begin
          r_next.word[`OAG_W_SUB_HI:`OAG_W_SUB_LO] = tmRdData[`OAG_W_SUB_HI:`OAG_W_SUB_LO];
          r_next.state = oag_pkg::S_INDEX;
        end
      end
      oag_pkg::S_REGIND: begin
        // All sources are read from the old word, so the overlaps are harmless
        r_next.word[`OAG_W_MOD_HI:`OAG_W_MOD_LO] =
          r_reg.word[`OAG_W_NMOD_HI:`OAG_W_NMOD_LO];
        r_next.word[`OAG_W_MODE] = r_reg.word[`OAG_W_NTAG];
        r_next.wbPending = r_reg.word[`OAG_W_WBK];
        r_next.savedSel = r_reg.word[`OAG_W_RSEL_HI:`OAG_W_RSEL_LO];
        r_next.word[`OAG_W_OP_HI:`OAG_W_OP_LO] = spRdData;
        r_next.state = oag_pkg::S_INDEX;
      end
      oag_pkg::S_FINAL: begin
        r_next.opInMain = 1'b0;
        r_next.opAddr = {`OAG_LIT_PAD, opField};
        if (!r_reg.word[`OAG_W_MODE]) begin
          r_next.opIsLiteral = 1'b1;
          r_next.state = oag_pkg::S_OUT;
        end else if (!virtualMode) begin
          r_next.opIsLiteral = 1'b0;
          r_next.state = oag_pkg::S_OUT;
        end else begin
          r_next.opIsLiteral = 1'b0;
          r_next.state = oag_pkg::S_KWRD;
        end
      end
      oag_pkg::S_KWRD: begin
        if (tmAck) begin
          r_next.kw = tmRdData;
          r_next.state = oag_pkg::S_KWCHK;
        end
      end
      oag_pkg::S_KWCHK: begin
        if (!r_reg.kw[`OAG_K_PW]) begin
          r_next.opInMain = 1'b1;
          r_next.opAddr = wordMainAddr;
          r_next.state = oag_pkg::S_OUT;
        end else if (r_reg.kw[`OAG_K_RES]) begin
          r_next.opAddr = {`OAG_LIT_PAD, resTmAddr};
          r_next.state = oag_pkg::S_OUT;
        end else begin
          r_next.cnt = `OAG_FIRST_WORD;
          r_next.loadPage = freePage;
          r_next.fromMain = (r_reg.kw[`OAG_K_UNIT_HI:`OAG_K_UNIT_LO] == mainUnitPrefix);
          r_next.state = oag_pkg::S_XFERRD;
        end
      end
      oag_pkg::S_XFERRD: begin
        if (srcAck) begin
          r_next.xbuf = srcData;
          r_next.state = oag_pkg::S_XFERWR;
        end
      end
      oag_pkg::S_XFERWR: begin
        if (tmAck) begin
          r_next.cnt = r_reg.cnt + 8'h01;
          if (r_reg.cnt == `OAG_LAST_WORD) begin
            r_next.state = oag_pkg::S_KWWR;
          end else begin
            r_next.state = oag_pkg::S_XFERRD;
          end
        end
      end
      oag_pkg::S_KWWR: begin
        if (tmAck) begin
          r_next.kw = kwNew;
          r_next.opAddr = {`OAG_LIT_PAD, loadTmAddr};
          r_next.state = oag_pkg::S_OUT;
        end
      end
      oag_pkg::S_OUT: begin
        if (opReady) begin
          r_next.state = oag_pkg::S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  chk_zero_index: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_INDEX && idxSel == `OAG_NO_INDEX) |=>
      opField == $past(opField)) else $error("operand changed with no index");
  chk_index_src: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_INDEX) |-> spRdAddr == {`OAG_IDX_PAD, idxSel})
    else $error("wrong index register read");
  chk_index_sum: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_INDEX && idxSel != `OAG_NO_INDEX) |=>
      opField == 16'($past(opField) + $past(spRdData))) else $error("bad index sum");
  chk_no_indirect: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_INDEX && !r_reg.word[`OAG_W_INDIR]) |=>
      r_reg.state == oag_pkg::S_FINAL) else $error("indirection without flag");
  chk_mode_pick: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_INDEX && r_reg.word[`OAG_W_INDIR]) |=>
      (r_reg.state == oag_pkg::S_MEMIND) == $past(r_reg.word[`OAG_W_MODE]))
    else $error("wrong indirect mode");
  chk_reg_rearrange: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_REGIND) |=>
      r_reg.savedSel == $past(r_reg.word[`OAG_W_RSEL_HI:`OAG_W_RSEL_LO]) &&
      r_reg.word[`OAG_W_MODE] == $past(r_reg.word[`OAG_W_NTAG]) &&
      opField == $past(spRdData)) else $error("bad register indirect step");
  chk_write_back: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_REGIND && r_reg.word[`OAG_W_WBK]) |=>
      spWrEn && spWrAddr == $past(r_reg.word[`OAG_W_RSEL_HI:`OAG_W_RSEL_LO]))
    else $error("write-back missing");
  chk_word_disp: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_KWCHK && !r_reg.kw[`OAG_K_PW]) |=>
      opAddr[7:0] == 8'($past(r_reg.kw[`OAG_K_DISP_HI:`OAG_K_DISP_LO]) +
                        $past(r_reg.word[`OAG_W_DISP_HI:`OAG_W_DISP_LO])))
    else $error("bad word displacement");
  chk_load_end: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_XFERWR && tmAck && r_reg.cnt != `OAG_LAST_WORD) |=>
      r_reg.state == oag_pkg::S_XFERRD) else $error("page load ended early");
  chk_resident_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_KWWR) |-> tmWe && tmWrData[`OAG_K_RES] &&
      tmWrData[`OAG_K_TMPG_HI:`OAG_K_TMPG_LO] == r_reg.loadPage)
    else $error("kernel word not marked resident");
  chk_mem_subst: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_MEMIND && tmAck) |=> r_reg.state == oag_pkg::S_INDEX &&
      r_reg.word[`OAG_W_SUB_HI:`OAG_W_SUB_LO] == $past(tmRdData[`OAG_W_SUB_HI:`OAG_W_SUB_LO]))
    else $error("memory indirect word not substituted");
  chk_literal_pick: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_FINAL && !r_reg.word[`OAG_W_MODE]) |=>
      opIsLiteral && opAddr == {`OAG_LIT_PAD, $past(opField)})
    else $error("literal operand not flagged");
  chk_stall_load: assert property (@(posedge clk_sys) disable iff (!resetn)
    (r_reg.state == oag_pkg::S_XFERRD || r_reg.state == oag_pkg::S_XFERWR) |-> !opValid)
    else $error("operand valid during page load");

endmodule

// file: sim/oag_mem_model.sv
`timescale 1ns/100ps

module oag_mem_model (
  // Clock, reset and answer speed
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [1:0] delay,
  // Task memory
  input wire logic tmReq,
  input wire logic tmWe,
  input wire logic [15:0] tmAddr,
  input wire logic [35:0] tmWrData,
  output logic [35:0] tmRdData,
  output logic tmAck,
  // Main data memory
  input wire logic mmReq,
  input wire logic [19:0] mmAddr,
  output logic [35:0] mmRdData,
  output logic mmAck,
  // Block read-only memory
  input wire logic romReq,
  input wire logic [27:0] romAddr,
  output logic [35:0] romRdData,
  output logic romAck
);
  logic [35:0] tmMem [65536];
  logic [15:0] mmCount = 16'h0000;
  logic [15:0] romCount = 16'h0000;
  logic [2:0] req;
  logic [2:0] ack;
  logic [2:0] fire;
  logic [1:0] waitCnt [3];

  // ------------------------------------------------
  // Handshake: answer after delay cycles, one-cycle ack
  // ------------------------------------------------
  assign req = {romReq, mmReq, tmReq};
  assign {romAck, mmAck, tmAck} = ack;

  always_comb begin
    for (int i = 0; i < 3; i++) fire[i] = req[i] && !ack[i] && waitCnt[i] == delay;
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack <= 3'h0;
      for (int i = 0; i < 3; i++) waitCnt[i] <= 2'h0;
    end else begin
      ack <= fire;
      for (int i = 0; i < 3; i++) waitCnt[i] <= (req[i] && !fire[i]) ? waitCnt[i] + 2'h1 : 2'h0;
    end
  end

  // ------------------------------------------------
  // Data: read data toggles outside the ack cycle, so a late capture sees garbage
  // ------------------------------------------------
  initial begin
    tmRdData = 36'h000000000;
    mmRdData = 36'h000000000;
    romRdData = 36'h000000000;
  end

  // Idle in reset: an unknown request there would stick in the counters for good
  always @(posedge clk_sys) begin
    if (resetn) begin
      if (fire[0] && tmWe) begin
        tmMem[tmAddr] <= tmWrData;
      end
      tmRdData <= fire[0] ? tmMem[tmAddr] : ~tmRdData;
      mmRdData <= fire[1] ? {16'h0000, mmAddr} : ~mmRdData;
      romRdData <= fire[2] ? {8'h00, romAddr} : ~romRdData;
      mmCount <= mmCount + {15'h0000, fire[1]};
      romCount <= romCount + {15'h0000, fire[2]};
    end
  end
endmodule

// file: sim/tb.sv
`timescale 1ns/100ps
`include "oag_consts.svh"

`define CHK(got, exp, msg) begin \
  totalChecks++; \
  if ((got) !== (exp)) begin \
    nFail++; \
    $display("[FAIL] %0t %s", $time, msg); \
  end \
end

module tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic instrValid = 1'b0;
  logic virtualMode = 1'b0;
  logic kprLoad = 1'b0;
  logic opReady = 1'b0;
  logic [35:0] instrWord = 36'h000000000;
  logic [3:0] mainUnitPrefix = 4'h2;
  logic [7:0] freePage = 8'h00;
  logic [1:0] kprIn = 2'h0;
  logic [1:0] memDelay = 2'h0;
  logic instrReady, spWrEn, tmReq, tmWe, tmAck, mmReq, mmAck, romReq, romAck;
  logic opValid, opIsLiteral, opInMain;
  logic [1:0] kernelPagePointer;
  logic [4:0] spRdAddr, spWrAddr;
  logic [15:0] spRdData, spWrData, tmAddr, m0, r0;
  logic [35:0] tmWrData, tmRdData, mmRdData, romRdData;
  logic [19:0] mmAddr, opAddr;
  logic [27:0] romAddr;
  logic [21:0] res;
  logic [15:0] spMem [32];
  int nFail = 0;
  int totalChecks = 0;
  int cycles = 0;

  oag_top i_oag_top (
    .clk_sys, .resetn, .instrValid, .instrWord, .instrReady, .virtualMode, .mainUnitPrefix,
    .freePage, .kprLoad, .kprIn, .kernelPagePointer, .spRdAddr, .spRdData, .spWrEn,
    .spWrAddr, .spWrData, .tmReq, .tmWe, .tmAddr, .tmWrData, .tmRdData, .tmAck, .mmReq,
    .mmAddr, .mmRdData, .mmAck, .romReq, .romAddr, .romRdData, .romAck, .opValid,
    .opIsLiteral, .opInMain, .opAddr, .opReady
  );

  oag_mem_model i_oag_mem_model (
    .clk_sys, .resetn, .delay(memDelay), .tmReq, .tmWe, .tmAddr, .tmWrData, .tmRdData,
    .tmAck, .mmReq, .mmAddr, .mmRdData, .mmAck, .romReq, .romAddr, .romRdData, .romAck
  );

  // ------------------------------------------------
  // Clock, scratchpad, timeout
  // ------------------------------------------------
  always #5 clk_sys = ~clk_sys;

  assign spRdData = spMem[spRdAddr];

  always @(posedge clk_sys) begin
    if (spWrEn) begin
      spMem[spWrAddr] <= spWrData;
    end
  end

  // Two page loads dominate the run; this ceiling is several times that
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      $display("[FAIL] %0t timeout", $time);
      tallyAndFinish();
    end
  end

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [35:0] mk(input logic [2:0] sel, input logic ind,
                                     input logic [15:0] op, input logic mode);
    logic [35:0] w;
    w = 36'h000000000;
    w[`OAG_W_SEL_HI:`OAG_W_SEL_LO] = sel;
    w[`OAG_W_INDIR] = ind;
    w[`OAG_W_OP_HI:`OAG_W_OP_LO] = op;
    w[`OAG_W_MODE] = mode;
    return w;
  endfunction

  // Task page, residency, page/word, address field; protection and parity zero
  function automatic logic [35:0] mkKw(input logic [7:0] pg, input logic rs,
                                       input logic pw, input logic [19:0] a);
    return {pg, 2'h0, rs, pw, a, 4'h0};
  endfunction

  task automatic runOp(input logic [35:0] w);
    @(negedge clk_sys);
    instrValid = 1'b1;
    instrWord = w;
    while (instrReady !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    instrValid = 1'b0;
    while (opValid !== 1'b1) @(negedge clk_sys);
    res = {opIsLiteral, opInMain, opAddr};
    opReady = 1'b1;
    @(negedge clk_sys);
    opReady = 1'b0;
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d failures %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    for (int i = 0; i < 32; i++) spMem[i] = 16'h0100 * i[15:0] + 16'h0010;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    `CHK({instrReady, opValid, kernelPagePointer}, 4'b1000, "reset state")
    runOp(mk(3'h0, 1'b0, 16'h1234, 1'b0));
    `CHK(res, {2'b10, 20'h01234}, "literal no index")
    for (int s = 1; s < 8; s++) begin
      runOp(mk(s[2:0], 1'b0, 16'hFFF8, 1'b1));
      `CHK(res, {6'h00, 16'hFFF8 + spMem[s]}, "index add")
    end
    memDelay = 2'h2;
    i_oag_mem_model.tmMem[16'h0040] = mk(3'h0, 1'b1, 16'h0041, 1'b1);
    i_oag_mem_model.tmMem[16'h0041] = mk(3'h2, 1'b0, 16'h3000, 1'b0);
    runOp(mk(3'h0, 1'b1, 16'h0040, 1'b1));
    `CHK(res, {2'b10, 20'h03210}, "memory indirect chain")
    runOp(mk(3'h0, 1'b1, 16'hC101, 1'b0));
    `CHK(res, {6'h00, 16'h1120}, "register indirect")
    `CHK(spMem[16], 16'h1120, "write-back")
    runOp(mk(3'h0, 1'b1, 16'h4101, 1'b0));
    `CHK(res, {6'h00, 16'h1230}, "register indirect plain")
    `CHK(spMem[16], 16'h1120, "no write-back")
    // Kernel pointer moves to task page 2 before any translation
    kprIn = 2'h2;
    kprLoad = 1'b1;
    @(negedge clk_sys);
    kprLoad = 1'b0;
    virtualMode = 1'b1;
    `CHK(kernelPagePointer, 2'h2, "pointer load")
    i_oag_mem_model.tmMem[16'h0203] = mkKw(8'h00, 1'b0, 1'b0, 20'h12320);
    runOp(mk(3'h0, 1'b0, 16'h03F0, 1'b1));
    `CHK(res, {2'b01, 20'h12310}, "word oriented")
    m0 = i_oag_mem_model.mmCount;
    i_oag_mem_model.tmMem[16'h0204] = mkKw(8'h07, 1'b1, 1'b1, 20'h2AB00);
    runOp(mk(3'h0, 1'b0, 16'h0437, 1'b1));
    `CHK(res, {2'b00, 20'h00737}, "resident page")
    memDelay = 2'h1;
    freePage = 8'h09;
    i_oag_mem_model.tmMem[16'h0205] = mkKw(8'h00, 1'b0, 1'b1, 20'h2ABFE);
    runOp(mk(3'h0, 1'b0, 16'h0511, 1'b1));
    `CHK(res, {2'b00, 20'h00911}, "main page load")
    `CHK(16'(i_oag_mem_model.mmCount - m0), 16'h0100, "words before answer")
    `CHK(i_oag_mem_model.tmMem[16'h0900], 36'h00002ABFE, "first word")
    `CHK(i_oag_mem_model.tmMem[16'h0902], 36'h00002AB00, "wrap")
    `CHK(i_oag_mem_model.tmMem[16'h09FF], 36'h00002ABFD, "last word")
    `CHK(i_oag_mem_model.tmMem[16'h0205][35:24], 12'h093, "kernel update")
    runOp(mk(3'h0, 1'b0, 16'h0512, 1'b1));
    `CHK(res, {2'b00, 20'h00912}, "now resident")
    `CHK(16'(i_oag_mem_model.mmCount - m0), 16'h0100, "no second load")
    r0 = i_oag_mem_model.romCount;
    freePage = 8'h0A;
    i_oag_mem_model.tmMem[16'h0206] = mkKw(8'h00, 1'b0, 1'b1, 20'h31456);
    runOp(mk(3'h0, 1'b0, 16'h0622, 1'b1));
    `CHK(res, {2'b00, 20'h00A22}, "rom page load")
    `CHK(16'(i_oag_mem_model.romCount - r0), 16'h0100, "rom words")
    `CHK(i_oag_mem_model.tmMem[16'h0A00], 36'h003145600, "rom first")
    `CHK(i_oag_mem_model.tmMem[16'h0AFF], 36'h0031456FF, "rom last")
    tallyAndFinish();
  end
endmodule
